// ==== shared/flh_defs.vh ====
/*
 * Constants for the parallel flash host controller: command codes, unlock
 * addresses, status bit positions and timing counts.
 * Assumes a 20 MHz system clock and a flash answering within 90 ns.
 */
`ifndef FLH_DEFS_VH
`define FLH_DEFS_VH

// User operation codes
`define FLH_OP_READ      4'h0
`define FLH_OP_RESET     4'h1
`define FLH_OP_IDENT     4'h2
`define FLH_OP_PROG      4'h3
`define FLH_OP_BERASE    4'h4
`define FLH_OP_CERASE    4'h5
`define FLH_OP_ADDBLK    4'h6
`define FLH_OP_SUSPEND   4'h7
`define FLH_OP_RESUME    4'h8

// Command data
`define FLH_D_UNLOCK1    16'h00AA
`define FLH_D_UNLOCK2    16'h0055
`define FLH_D_RESET      16'h00F0
`define FLH_D_IDENT      16'h0090
`define FLH_D_PROG       16'h00A0
`define FLH_D_SETUP_ER   16'h0080
`define FLH_D_BLK_ER     16'h0030
`define FLH_D_CHIP_ER    16'h0010
`define FLH_D_SUSPEND    16'h00B0

// Unlock addresses, byte and word configuration
`define FLH_A_U1_BYTE    19'h0AAAA
`define FLH_A_U2_BYTE    19'h05555
`define FLH_A_U1_WORD    19'h05555
`define FLH_A_U2_WORD    19'h02AAA

// Status bit positions and reserved mask
`define FLH_B_POLL       7
`define FLH_B_TOGGLE     6
`define FLH_B_FAIL       5
`define FLH_B_WINDOW     3
`define FLH_STAT_MASK    16'hFFEC

// Write sequence steps
`define FLH_STEP_SINGLE  3'h7
`define FLH_STEP_PROG    3'h3
`define FLH_STEP_ERASE   3'h5
`define FLH_STEP_IDENT   3'h2

// Bus cycle timing
`define FLH_RD_SAMPLE    3'h6
`define FLH_WR_RELEASE   3'h2

// Wait after reset during erase
`define FLH_CLK_NS       50
`define FLH_T_RST_NS     10000
`define FLH_RST_WAIT_CYC ((`FLH_T_RST_NS + `FLH_CLK_NS - 1) / `FLH_CLK_NS)

`endif

// ==== core/flh_bus_cycle.v ====
/*
 * One asynchronous flash bus cycle, read or write, from registered pins.
 * Assumes the caller pulses start only while done paths are idle; data
 * input arrives from the pin and is synchronised here.
 */
`include "flh_defs.vh"

module flh_bus_cycle (
  input  wire        clk,
  input  wire        rst,
  input  wire        start,
  input  wire        wr,
  input  wire [18:0] addr,
  input  wire [15:0] wdata,
  output reg         done_r,
  output reg  [15:0] rdata_r,
  output reg         fl_ce_n_r,
  output reg         fl_oe_n_r,
  output reg         fl_we_n_r,
  output reg  [18:0] fl_addr_r,
  output reg  [15:0] fl_dq_o_r,
  output reg         fl_dq_oe_r,
  input  wire [15:0] fl_dq_i
);

  reg        busy_r;
  reg        wr_r;
  reg [2:0]  cnt_r;
  reg [15:0] dq_s1_r;
  reg [15:0] dq_s2_r;

  always @(posedge clk) begin
    dq_s1_r <= fl_dq_i;
    dq_s2_r <= dq_s1_r;
  end

  always @(posedge clk) begin
    if (rst) begin
      busy_r     <= 1'b0;
      wr_r       <= 1'b0;
      cnt_r      <= 3'h0;
      done_r     <= 1'b0;
      rdata_r    <= 16'h0000;
      fl_ce_n_r  <= 1'b1;
      fl_oe_n_r  <= 1'b1;
      fl_we_n_r  <= 1'b1;
      fl_addr_r  <= 19'h00000;
      fl_dq_o_r  <= 16'h0000;
      fl_dq_oe_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (start) begin
          busy_r     <= 1'b1;
          wr_r       <= wr;
          cnt_r      <= 3'h0;
          fl_ce_n_r  <= 1'b0;
          fl_addr_r  <= addr;
          fl_dq_o_r  <= wdata;
          fl_dq_oe_r <= wr;
        end
      end else begin
        cnt_r <= cnt_r + 3'h1;
        if (wr_r) begin
          if (cnt_r == 3'h0)
            fl_we_n_r <= 1'b0;
          else if (cnt_r == 3'h1)
            fl_we_n_r <= 1'b1;
          else if (cnt_r == `FLH_WR_RELEASE) begin
            fl_ce_n_r  <= 1'b1;
            fl_dq_oe_r <= 1'b0;
            busy_r     <= 1'b0;
            done_r     <= 1'b1;
          end
        end else begin
          // Each read is a fresh chip-select and output-strobe pulse
          if (cnt_r == 3'h0)
            fl_oe_n_r <= 1'b0;
          else if (cnt_r == `FLH_RD_SAMPLE) begin
            rdata_r   <= dq_s2_r;
            fl_oe_n_r <= 1'b1;
            fl_ce_n_r <= 1'b1;
            busy_r    <= 1'b0;
            done_r    <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ==== core/flh_ctrl.v ====
/*
 * Host controller for an asynchronous parallel flash: issues unlock and
 * command sequences, reads, and polls the status toggle bits.
 * Assumes a flash on the pins and a user issuing one order at a time.
 */
// Summary of operation
// - Add blocks only while erase-window flag low
// - Poll at programmed address after command
// - Toggle flag flips each read while busy
// - First unlock: AAh to first unlock address
// - Second unlock: 55h to second address
// - Wait 10us after reset during erase
// - Host masks reserved status bits 0,1,4
`include "flh_defs.vh"

module flh_ctrl (
  input  wire        clk,
  input  wire        rst,
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_op,
  input  wire [18:0] cmd_addr,
  input  wire [15:0] cmd_data,
  input  wire        cmd_nopoll,
  input  wire        byte_mode,
  output reg         cmd_ready_r,
  output reg         rsp_valid_r,
  output reg  [15:0] rsp_data_r,
  output reg         rsp_fail_r,
  output reg         rsp_refused_r,
  output reg         erase_active_r,
  output reg         fl_byte_n_r,
  output wire        fl_ce_n,
  output wire        fl_oe_n,
  output wire        fl_we_n,
  output wire [18:0] fl_addr,
  output wire [15:0] fl_dq_o,
  output wire        fl_dq_oe,
  input  wire [15:0] fl_dq_i
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_WR   = 6'h02;
  localparam [5:0] S_RD   = 6'h04;
  localparam [5:0] S_POLL = 6'h08;
  localparam [5:0] S_WAIT = 6'h10;
  localparam [5:0] S_DONE = 6'h20;

  localparam integer RST_WAIT_I = `FLH_RST_WAIT_CYC;
  localparam [7:0]   RST_WAIT   = RST_WAIT_I[7:0];

  reg [5:0]  state_r;
  reg [3:0]  op_r;
  reg [18:0] addr_r;
  reg [15:0] data_r;
  reg        nopoll_r;
  reg [2:0]  step_r;
  reg        issued_r;
  reg        start_r;
  reg        wr_r;
  reg        pair_r;
  reg        fail_chk_r;
  reg [15:0] prev_r;
  reg [7:0]  wait_r;
  reg [18:0] w_addr;
  reg [15:0] w_data;
  reg [2:0]  last_step;
  reg [18:0] u1;
  reg [18:0] u2;
  wire       cyc_done;
  wire [15:0] cyc_rdata;
  wire [15:0] stat;

  assign stat = cyc_rdata & `FLH_STAT_MASK;

  flh_bus_cycle u_cyc (
    .clk        (clk),
    .rst        (rst),
    .start      (start_r),
    .wr         (wr_r),
    .addr       (wr_r ? w_addr : addr_r),
    .wdata      (w_data),
    .done_r     (cyc_done),
    .rdata_r    (cyc_rdata),
    .fl_ce_n_r  (fl_ce_n),
    .fl_oe_n_r  (fl_oe_n),
    .fl_we_n_r  (fl_we_n),
    .fl_addr_r  (fl_addr),
    .fl_dq_o_r  (fl_dq_o),
    .fl_dq_oe_r (fl_dq_oe),
    .fl_dq_i    (fl_dq_i)
  );

  // Write sequence table; unlock-address steps keep upper address bits zero, addr_r steps do not
  always @* begin
    u1 = fl_byte_n_r ? `FLH_A_U1_WORD : `FLH_A_U1_BYTE;
    u2 = fl_byte_n_r ? `FLH_A_U2_WORD : `FLH_A_U2_BYTE;
    w_addr = u1;
    w_data = `FLH_D_UNLOCK1;
    case (step_r)
      3'h0: begin
        w_addr = u1;
        w_data = `FLH_D_UNLOCK1;
      end
      3'h1: begin
        w_addr = u2;
        w_data = `FLH_D_UNLOCK2;
      end
      3'h2: begin
        w_addr = u1;
        if (op_r == `FLH_OP_PROG)
          w_data = `FLH_D_PROG;
        else if (op_r == `FLH_OP_IDENT)
          w_data = `FLH_D_IDENT;
        else
          w_data = `FLH_D_SETUP_ER;
      end
      3'h3: begin
        if (op_r == `FLH_OP_PROG) begin
          w_addr = addr_r;
          w_data = data_r;
        end else begin
          w_addr = u1;
          w_data = `FLH_D_UNLOCK1;
        end
      end
      3'h4: begin
        w_addr = u2;
        w_data = `FLH_D_UNLOCK2;
      end
      3'h5: begin
        if (op_r == `FLH_OP_CERASE) begin
          w_addr = u1;
          w_data = `FLH_D_CHIP_ER;
        end else begin
          w_addr = addr_r;
          w_data = `FLH_D_BLK_ER;
        end
      end
      3'h7: begin
        w_addr = addr_r;
        if (op_r == `FLH_OP_RESET)
          w_data = `FLH_D_RESET;
        else if (op_r == `FLH_OP_SUSPEND)
          w_data = `FLH_D_SUSPEND;
        else
          w_data = `FLH_D_BLK_ER;
      end
      default: begin
        w_addr = u1;
        w_data = `FLH_D_UNLOCK1;
      end
    endcase
    case (op_r)
      `FLH_OP_PROG:   last_step = `FLH_STEP_PROG;
      `FLH_OP_BERASE: last_step = `FLH_STEP_ERASE;
      `FLH_OP_CERASE: last_step = `FLH_STEP_ERASE;
      `FLH_OP_IDENT:  last_step = `FLH_STEP_IDENT;
      default:        last_step = `FLH_STEP_SINGLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r        <= S_IDLE;
      op_r           <= `FLH_OP_READ;
      addr_r         <= 19'h00000;
      data_r         <= 16'h0000;
      nopoll_r       <= 1'b0;
      step_r         <= 3'h0;
      issued_r       <= 1'b0;
      start_r        <= 1'b0;
      wr_r           <= 1'b0;
      pair_r         <= 1'b0;
      fail_chk_r     <= 1'b0;
      prev_r         <= 16'h0000;
      wait_r         <= 8'h00;
      cmd_ready_r    <= 1'b1;
      rsp_valid_r    <= 1'b0;
      rsp_data_r     <= 16'h0000;
      rsp_fail_r     <= 1'b0;
      rsp_refused_r  <= 1'b0;
      erase_active_r <= 1'b0;
      fl_byte_n_r    <= 1'b1;
    end else begin
      start_r     <= 1'b0;
      rsp_valid_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_valid) begin
            cmd_ready_r   <= 1'b0;
            op_r          <= cmd_op;
            addr_r        <= cmd_addr;
            data_r        <= cmd_data;
            nopoll_r      <= cmd_nopoll;
            fl_byte_n_r   <= ~byte_mode;
            issued_r      <= 1'b0;
            pair_r        <= 1'b0;
            fail_chk_r    <= 1'b0;
            rsp_fail_r    <= 1'b0;
            rsp_refused_r <= 1'b0;
            if (cmd_op == `FLH_OP_READ || cmd_op == `FLH_OP_ADDBLK)
              state_r <= S_RD;
            else begin
              state_r <= S_WR;
              if (cmd_op == `FLH_OP_PROG || cmd_op == `FLH_OP_BERASE ||
                  cmd_op == `FLH_OP_CERASE || cmd_op == `FLH_OP_IDENT)
                step_r <= 3'h0;
              else
                step_r <= `FLH_STEP_SINGLE;
            end
          end
        end
        S_WR: begin
          if (!issued_r) begin
            issued_r <= 1'b1;
            start_r  <= 1'b1;
            wr_r     <= 1'b1;
          end else if (cyc_done) begin
            issued_r <= 1'b0;
            if (step_r != last_step)
              step_r <= step_r + 3'h1;
            else begin
              if (op_r == `FLH_OP_BERASE || op_r == `FLH_OP_CERASE)
                erase_active_r <= 1'b1;
              if (op_r == `FLH_OP_IDENT)
                state_r <= S_RD;
              else if ((op_r == `FLH_OP_PROG || op_r == `FLH_OP_BERASE ||
                        op_r == `FLH_OP_CERASE || op_r == `FLH_OP_RESUME) &&
                       !nopoll_r)
                state_r <= S_POLL;
              else if (op_r == `FLH_OP_RESET && erase_active_r) begin
                wait_r  <= 8'h00;
                state_r <= S_WAIT;
              end else
                state_r <= S_DONE;
            end
          end
        end
        S_RD: begin
          if (!issued_r) begin
            issued_r <= 1'b1;
            start_r  <= 1'b1;
            wr_r     <= 1'b0;
          end else if (cyc_done) begin
            issued_r   <= 1'b0;
            rsp_data_r <= (op_r == `FLH_OP_ADDBLK) ? stat : cyc_rdata;
            if (op_r == `FLH_OP_ADDBLK) begin
              if (!cyc_rdata[`FLH_B_WINDOW]) begin
                step_r  <= `FLH_STEP_SINGLE;
                state_r <= S_WR;
              end else begin
                rsp_refused_r <= 1'b1;
                state_r       <= S_DONE;
              end
            end else
              state_r <= S_DONE;
          end
        end
        S_POLL: begin
          // Two reads in a row; equal toggle bits mean the operation ended
          if (!issued_r) begin
            issued_r <= 1'b1;
            start_r  <= 1'b1;
            wr_r     <= 1'b0;
          end else if (cyc_done) begin
            issued_r <= 1'b0;
            if (!pair_r) begin
              prev_r <= stat;
              pair_r <= 1'b1;
            end else begin
              pair_r     <= 1'b0;
              rsp_data_r <= stat;
              if (prev_r[`FLH_B_TOGGLE] == stat[`FLH_B_TOGGLE]) begin
                erase_active_r <= 1'b0;
                state_r        <= S_DONE;
              end else if (fail_chk_r) begin
                rsp_fail_r     <= 1'b1;
                erase_active_r <= 1'b0;
                state_r        <= S_DONE;
              end else if (stat[`FLH_B_FAIL])
                fail_chk_r <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          wait_r <= wait_r + 8'h01;
          if (wait_r == RST_WAIT - 8'h01) begin
            erase_active_r <= 1'b0;
            state_r        <= S_DONE;
          end
        end
        S_DONE: begin
          rsp_valid_r <= 1'b1;
          cmd_ready_r <= 1'b1;
          state_r     <= S_IDLE;
        end
        default: begin
          state_r     <= S_IDLE;
          cmd_ready_r <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== tb/flh_flash_model.sv ====
/* Behavioural parallel flash that answers the controller's strobes.
   Assumes host data on dq_in and the bench muxing dq_out onto the bus. */
module flh_flash_model #(
  parameter BUSY_N = 6,
  parameter WIN_N  = 2,
  parameter MAKER  = 16'h0033,
  parameter PART   = 16'h0044,
  parameter PROT   = 6'h01
) (
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        byte_n,
  input  wire [18:0] addr,
  input  wire [15:0] dq_in,
  output wire [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // MAKER and PART values are arbitrary; BUSY_N and WIN_N count reads
  reg [15:0] mem [0:15];
  reg [15:0] rd = 16'h0000, pd = 16'hFFFF;
  reg [18:0] wa, ra;
  reg [7:0]  d;
  reg        tog = 1'b0, fl = 1'b0, u1, u2;
  integer    st = 0, ul = 0, cnt = 0, pa = 0, i;
  initial for (i = 0; i < 16; i++) mem[i] = 16'hFFFF;
  // Released bus shows the inverse of the last value
  assign dq_out = (!ce_n && !oe_n) ? rd : ~rd;
  always @(posedge we_n) if (!ce_n) begin
    d = dq_in[7:0];
    wa = byte_n ? addr : addr >> 1;
    u1 = byte_n ? addr[14:0] == 15'h5555 : addr[15:0] == 16'hAAAA;
    u2 = byte_n ? addr[14:0] == 15'h2AAA : addr[15:0] == 16'h5555;
    if (st == 6 || st == 7) begin
      if (d == 8'hF0) begin
        st = 0;
        fl = 1'b0;
      end else if (d == 8'hB0 && st == 7) st = 8;
    end else if (st == 8) st = d == 8'h30 ? 7 : d == 8'hF0 ? 0 : 8;
    else if (st == 2) begin
      pa = wa[3:0];
      pd = byte_n ? dq_in : {8'hFF, d};
      fl = |(pd & ~mem[pa]);
      cnt = 0;
      st = 6;
    end else if (st == 3 || st == 4) begin
      st = (st == 3 ? d == 8'hAA && u1 : d == 8'h55 && u2) ? st + 1 : 0;
    end else if (st == 5) begin
      st = (d == 8'h30 || d == 8'h10) ? 7 : 0;
      cnt = 0;
    end else if (d == 8'hF0) begin
      st = 0;
      ul = 0;
    end else if (ul == 0) ul = d == 8'hAA && u1;
    else if (ul == 1) ul = d == 8'h55 && u2 ? 2 : 0;
    else begin
      ul = 0;
      st = d == 8'h90 ? 1 : d == 8'hA0 ? 2 : d == 8'h80 ? 3 : 0;
    end
  end
  always @(negedge oe_n) if (!ce_n) begin
    ra = byte_n ? addr : addr >> 1;
    if (st == 6 || st == 7) begin
      tog = ~tog;
      rd = {8'h00, st == 6 && !pd[7], tog, fl, 1'b1, st == 7 && cnt >= WIN_N, st == 6 || tog,
            2'b11};
      cnt = cnt + 1;
      if (cnt >= BUSY_N && !fl) begin
        if (st == 6) mem[pa] = mem[pa] & pd;
        else for (i = 0; i < 16; i++) mem[i] = 16'hFFFF;
        st = 0;
      end
    end else if (st == 8) begin
      tog = ~tog;
      rd = {8'h00, 2'b11, fl, 2'b11, tog, 2'b11};
    end else if (st == 1) begin
      rd = ra[1:0] == 2'b00 ? MAKER : ra[1:0] == 2'b01 ? PART : {15'h0000, ra[17:12] == PROT};
    end else rd = mem[ra[3:0]];
  end
endmodule

// ==== tb/flh_ctrl_properties.sv ====
/* Concurrent checks on the flash controller's ports.
   Assumes a single clock and synchronous active-high reset. */
module flh_ctrl_props (
  input wire        clk,
  input wire        rst,
  input wire        cmd_valid,
  input wire        cmd_ready_r,
  input wire        rsp_valid_r,
  input wire        fl_byte_n_r,
  input wire        fl_ce_n,
  input wire        fl_oe_n,
  input wire        fl_we_n,
  input wire        fl_dq_oe,
  input wire [18:0] fl_addr,
  input wire [15:0] fl_dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence wr_end;
    $rose(fl_we_n) && $stable(fl_addr) && $stable(fl_dq_o) ##1 fl_ce_n && !fl_dq_oe;
  endsequence
  sequence rd_hold;
    !fl_oe_n [*5] ##1 fl_oe_n && fl_ce_n;
  endsequence
  a_write_setup: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n) && fl_dq_oe && fl_oe_n)
    else $error("write strobe without select or data");
  a_write_pulse: assert property ($fell(fl_we_n) |=> wr_end)
    else $error("write cycle shape wrong");
  a_read_length: assert property ($fell(fl_oe_n) |-> !fl_ce_n && !fl_dq_oe ##1 rd_hold)
    else $error("read cycle shape wrong");
  a_bus_contend: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
    else $error("host drives bus while flash outputs");
  a_unlock_first: assert property ($fell(fl_we_n) && fl_dq_o[7:0] == 8'hAA |->
    (fl_byte_n_r ? fl_addr[14:0] == 15'h5555 : fl_addr[15:0] == 16'hAAAA))
    else $error("first unlock address wrong");
  a_unlock_second: assert property ($fell(fl_we_n) && fl_dq_o[7:0] == 8'h55 |->
    (fl_byte_n_r ? fl_addr[14:0] == 15'h2AAA : fl_addr[15:0] == 16'h5555))
    else $error("second unlock address wrong");
  a_take_drop: assert property (cmd_valid && cmd_ready_r |=> !cmd_ready_r)
    else $error("ready stayed high after take");
  a_ready_rise: assert property ($rose(cmd_ready_r) |-> rsp_valid_r)
    else $error("ready rose without response");
  a_rsp_pulse: assert property (rsp_valid_r |=> !rsp_valid_r)
    else $error("response longer than one cycle");
  a_idle_quiet: assert property (cmd_ready_r |-> fl_ce_n && fl_we_n && fl_oe_n && !fl_dq_oe)
    else $error("bus active while idle");
endmodule
bind flh_ctrl flh_ctrl_props i_props (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready_r(cmd_ready_r), .rsp_valid_r(rsp_valid_r), .fl_byte_n_r(fl_byte_n_r),
  .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_oe(fl_dq_oe),
  .fl_addr(fl_addr), .fl_dq_o(fl_dq_o));

// ==== tb/flh_ctrl_tb_top.sv ====
/* Self-checking bench for the flash controller with a flash model.
   Assumes the model's default codes and read counts. */
`include "flh_defs.vh"
module flh_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, cmd_valid, cmd_nopoll, byte_mode;
  logic [3:0]  cmd_op;
  logic [18:0] cmd_addr;
  logic [15:0] cmd_data;
  wire         cmd_ready_r, rsp_valid_r, rsp_fail_r, rsp_refused_r, erase_active_r;
  wire         fl_byte_n_r, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
  wire [18:0]  fl_addr;
  wire [15:0]  rsp_data_r, fl_dq_o, fl_dq_i, mem_dq;
  integer      num_errors = 0, tests_run = 0, cyc = 0, lat, k;
  logic [18:0] id_a [4] = '{19'h00000, 19'h00001, 19'h01002, 19'h02002};
  logic [15:0] id_e [4] = '{16'h0033, 16'h0044, 16'h0001, 16'h0000};
  assign fl_dq_i = fl_dq_oe ? fl_dq_o : mem_dq;
  flh_ctrl i_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_nopoll(cmd_nopoll), .byte_mode(byte_mode),
    .cmd_ready_r(cmd_ready_r), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
    .rsp_fail_r(rsp_fail_r), .rsp_refused_r(rsp_refused_r), .erase_active_r(erase_active_r),
    .fl_byte_n_r(fl_byte_n_r), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i));
  flh_flash_model i_mem (.ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .byte_n(fl_byte_n_r),
    .addr(fl_addr), .dq_in(fl_dq_o), .dq_out(mem_dq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic do_op(input [3:0] op, input [18:0] a, input [15:0] d, input np, input bm);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_nopoll <= np;
    byte_mode <= bm;
    @(negedge clk);
    while (cmd_ready_r !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    lat = 0;
    @(negedge clk);
    while (rsp_valid_r !== 1'b1 && lat < 9000) begin
      @(negedge clk);
      lat++;
    end
    if (lat >= 9000) begin
      num_errors++;
      $display("Error response wait expected pulse seen none");
      finish_test;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test;
    end
  end
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_addr = 19'h00000;
    cmd_data = 16'h0000;
    cmd_nopoll = 1'b0;
    byte_mode = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    do_op(`FLH_OP_READ, 19'h00003, 16'h0000, 1'b0, 1'b0);
    chk16("array read", 16'hFFFF, rsp_data_r);
    do_op(`FLH_OP_PROG, 19'h00003, 16'h00F0, 1'b0, 1'b0);
    chk1("program fail", 1'b0, rsp_fail_r);
    do_op(`FLH_OP_PROG, 19'h0000A, 16'h000F, 1'b0, 1'b1);
    do_op(`FLH_OP_READ, 19'h0000A, 16'h0000, 1'b0, 1'b1);
    chk16("byte program", 16'hFF0F, rsp_data_r);
    do_op(`FLH_OP_PROG, 19'h00003, 16'h00FF, 1'b0, 1'b0);
    chk1("overwrite fail", 1'b1, rsp_fail_r);
    do_op(`FLH_OP_RESET, 19'h00000, 16'h0000, 1'b0, 1'b0);
    do_op(`FLH_OP_READ, 19'h00003, 16'h0000, 1'b0, 1'b0);
    chk16("word program", 16'h00F0, rsp_data_r);
    for (k = 0; k < 4; k++) begin
      do_op(`FLH_OP_IDENT, id_a[k], 16'h0000, 1'b0, 1'b0);
      chk16("ident read", id_e[k], rsp_data_r);
    end
    do_op(`FLH_OP_BERASE, 19'h00003, 16'h0000, 1'b1, 1'b0);
    chk1("erase active", 1'b1, erase_active_r);
    do_op(`FLH_OP_ADDBLK, 19'h00010, 16'h0000, 1'b0, 1'b0);
    chk1("add accepted", 1'b0, rsp_refused_r);
    chk16("masked status", 16'h0000, rsp_data_r & 16'h001B);
    do_op(`FLH_OP_SUSPEND, 19'h00003, 16'h0000, 1'b0, 1'b0);
    do_op(`FLH_OP_READ, 19'h00003, 16'h0000, 1'b0, 1'b0);
    chk16("suspend flags", 16'h00C0, rsp_data_r & 16'h00C0);
    do_op(`FLH_OP_RESUME, 19'h00003, 16'h0000, 1'b0, 1'b0);
    chk1("erase done", 1'b0, erase_active_r);
    do_op(`FLH_OP_READ, 19'h00003, 16'h0000, 1'b0, 1'b0);
    chk16("erased read", 16'hFFFF, rsp_data_r);
    do_op(`FLH_OP_CERASE, 19'h00000, 16'h0000, 1'b1, 1'b0);
    for (k = 0; k < 3; k++) begin
      do_op(`FLH_OP_ADDBLK, 19'h00003, 16'h0000, 1'b0, 1'b0);
      chk1("add refused", k == 2, rsp_refused_r);
    end
    do_op(`FLH_OP_RESET, 19'h00000, 16'h0000, 1'b0, 1'b0);
    chk1("reset wait", 1'b1, lat >= `FLH_RST_WAIT_CYC);
    do_op(`FLH_OP_READ, 19'h00003, 16'h0000, 1'b0, 1'b0);
    chk16("read after reset", 16'hFFFF, rsp_data_r);
    finish_test;
  end
endmodule
